// >>> src/lpc_defines.vh
/*
 * Constants of the power-up and command controller: timing figures in
 * their own units, cycle counts derived from them, command codes and the
 * layout of a queued command word.
 * Assumes a 250 MHz system clock; included by every design file.
 */
`ifndef LPC_DEFINES_VH
`define LPC_DEFINES_VH

// System clock period
`define LPC_CLK_PS 4000

// Power-up times as specified
`define LPC_INIT1_NS 100
`define LPC_INIT2_TCK 5
`define LPC_INIT3_US 200
`define LPC_INIT4_US 1
`define LPC_INIT5_US 10
`define LPC_BOOT_CK_MIN_NS 18
`define LPC_BOOT_CK_MAX_NS 100

// Minimum times round up, maximum times round down
`define LPC_INIT1_CYC ((`LPC_INIT1_NS * 1000 + `LPC_CLK_PS - 1) / `LPC_CLK_PS)
`define LPC_INIT3_CYC ((`LPC_INIT3_US * 1000000 + `LPC_CLK_PS - 1) / `LPC_CLK_PS)
`define LPC_INIT4_CYC ((`LPC_INIT4_US * 1000000 + `LPC_CLK_PS - 1) / `LPC_CLK_PS)
`define LPC_INIT5_CYC ((`LPC_INIT5_US * 1000000) / `LPC_CLK_PS)

// Bus widths
`define LPC_CA_W 10
`define LPC_BANK_W 3
`define LPC_ROW_W 13
`define LPC_COL_W 11
`define LPC_OP_W 3
`define LPC_WORD_W 30
`define LPC_CNT_W 17

// User opcodes
`define LPC_OP_NOP 3'h0
`define LPC_OP_READ 3'h1
`define LPC_OP_WRITE 3'h2
`define LPC_OP_PRE 3'h3
`define LPC_OP_MRW 3'h4
`define LPC_OP_MRR 3'h5

// Command codes driven on the first half of the command/address bus
`define LPC_CODE_NOP 4'h0
`define LPC_CODE_ACT 4'h1
`define LPC_CODE_READ 4'h2
`define LPC_CODE_WRITE 4'h3
`define LPC_CODE_PRE 4'h4
`define LPC_CODE_PREA 4'h5
`define LPC_CODE_MRW 4'h6
`define LPC_CODE_MRR 4'h7

// Mode register address used by the reset write
`define LPC_MA_RESET 8'h3f

// Command word fields: {op, bank, row, col}
`define LPC_F_OP 29:27
`define LPC_F_BANK 26:24
`define LPC_F_ROW 23:11
`define LPC_F_COL 10:0

`endif

// >>> src/lpc_fifo.v
/*
 * Small synchronous FIFO holding queued command words.
 * Assumes one clock and a synchronous active-high reset; DEPTH must be a
 * power of two and AW its log2.
 */
`include "lpc_defines.vh"

module lpc_fifo #(
    parameter WIDTH = `LPC_WORD_W,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Fill side
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    reg [AW:0] next_count;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];

    // Occupancy after this cycle's push and pop
    always @* begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + 1'b1;
        end else if (pop & ~push) begin
            next_count = count - 1'b1;
        end
    end

    // Ready is registered so the source sees a flop, at the cost of
    // refusing a push in the same cycle as a pop while the queue is full
    always @(posedge clk) begin
        if (srst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= (next_count != DEPTH[AW:0]);
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Storage has no reset; contents are only read while valid
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// >>> src/lpc_ca_pack.v
/*
 * Packs one command into the two halves of the command/address bus, the
 * half sent on the rising clock edge and the half sent on the falling.
 * Purely combinational; the caller registers the result.
 */
`include "lpc_defines.vh"

module lpc_ca_pack (
    // Command to encode
    input wire [3:0] code,
    input wire [`LPC_BANK_W-1:0] bank,
    input wire [`LPC_ROW_W-1:0] row,
    input wire [`LPC_COL_W-1:0] col,
    // Bus halves
    output reg [`LPC_CA_W-1:0] ca_rise,
    output reg [`LPC_CA_W-1:0] ca_fall
);
    // Mode register commands carry address in col[7:0] and data in row[7:0]
    always @* begin
        ca_rise = {6'h00, code};
        ca_fall = 10'h000;
        case (code)
            `LPC_CODE_ACT: begin
                ca_rise = {row[2:0], bank, code};
                ca_fall = row[12:3];
            end
            `LPC_CODE_READ, `LPC_CODE_WRITE: begin
                ca_rise = {col[2:0], bank, code};
                ca_fall = {2'h0, col[10:3]};
            end
            `LPC_CODE_PRE, `LPC_CODE_PREA: begin
                ca_rise = {3'h0, bank, code};
            end
            `LPC_CODE_MRW, `LPC_CODE_MRR: begin
                ca_rise = {col[5:0], code};
                ca_fall = {row[7:0], col[7:6]};
            end
            default: begin
                ca_rise = {6'h00, code};
                ca_fall = 10'h000;
            end
        endcase
    end
endmodule

// >>> src/lpc_ctrl.v
/*
 * Host-side controller for a low-power DDR memory channel: runs the
 * power-up sequence up to the mode-register reset and auto-init wait,
 * then issues queued user commands, opening rows as needed.
 * Assumes a PHY that launches CA_RISE on the rising and CA_FALL on the
 * falling edge of the memory clock, and gates the clock with CK_EN.
 * RAMP_DONE and DAI_DONE come from outside and are synchronised here.
 */
`include "lpc_defines.vh"

module lpc_ctrl #(
    parameter INIT3_CYC = `LPC_INIT3_CYC,
    parameter BANKS = 8,
    parameter USE_PREA = 1,
    parameter CK_PERIOD_NS = 4
) (
    // Clock and reset
    input wire CLK,
    input wire SRST,
    // Board status pins
    input wire RAMP_DONE,
    input wire DAI_DONE,
    // User command stream
    input wire CMD_VALID,
    output wire CMD_READY,
    input wire [`LPC_OP_W-1:0] CMD_OP,
    input wire [`LPC_BANK_W-1:0] CMD_BANK,
    input wire [`LPC_ROW_W-1:0] CMD_ROW,
    input wire [`LPC_COL_W-1:0] CMD_COL,
    // Memory command pins
    output reg CK_EN,
    output reg CKE,
    output reg CS_N,
    output reg [`LPC_CA_W-1:0] CA_RISE,
    output reg [`LPC_CA_W-1:0] CA_FALL,
    // Status
    output reg INIT_DONE,
    output reg RELAXED
);
    localparam S_RAMP = 3'h0;
    localparam S_HOLD = 3'h1;
    localparam S_IDLE = 3'h2;
    localparam S_PREA = 3'h3;
    localparam S_RST = 3'h4;
    localparam S_DAI = 3'h5;
    localparam S_RUN = 3'h6;

    // Counts worked out as integers, then cut to the counter's width
    localparam integer HOLD_N = (`LPC_INIT1_CYC > `LPC_INIT2_TCK)
        ? `LPC_INIT1_CYC : `LPC_INIT2_TCK;
    localparam integer IDLE_N = INIT3_CYC;
    localparam integer INIT4_N = `LPC_INIT4_CYC;
    localparam integer INIT5_N = `LPC_INIT5_CYC;
    localparam [`LPC_CNT_W-1:0] HOLD_CYC = HOLD_N[`LPC_CNT_W-1:0];
    localparam [`LPC_CNT_W-1:0] IDLE_CYC = IDLE_N[`LPC_CNT_W-1:0];
    localparam [`LPC_CNT_W-1:0] INIT4_CYC = INIT4_N[`LPC_CNT_W-1:0];
    localparam [`LPC_CNT_W-1:0] INIT5_CYC = INIT5_N[`LPC_CNT_W-1:0];
    // Polling by mode register read is only legal at a slow boot clock
    localparam BOOT_MRR_OK = (CK_PERIOD_NS >= `LPC_BOOT_CK_MIN_NS) &&
        (CK_PERIOD_NS <= `LPC_BOOT_CK_MAX_NS);

    reg [2:0] state;
    reg [2:0] next_state;
    reg [`LPC_CNT_W-1:0] cnt;
    reg ramp_meta;
    reg ramp_sync;
    reg dai_meta;
    reg dai_sync;
    reg [BANKS-1:0] bank_open;
    reg [`LPC_ROW_W-1:0] open_row [0:BANKS-1];
    reg [3:0] next_code;
    reg next_cke;
    reg pop;
    reg set_open;
    reg clr_open;
    reg clr_all;
    reg [`LPC_BANK_W-1:0] next_bank;
    reg [`LPC_ROW_W-1:0] next_row;
    reg [`LPC_COL_W-1:0] next_col;
    wire q_valid;
    wire [`LPC_WORD_W-1:0] q_word;
    wire [`LPC_OP_W-1:0] q_op;
    wire [`LPC_BANK_W-1:0] q_bank;
    wire [`LPC_ROW_W-1:0] q_row;
    wire [`LPC_COL_W-1:0] q_col;
    wire [`LPC_CA_W-1:0] pk_rise;
    wire [`LPC_CA_W-1:0] pk_fall;

    // Tells whether the queued access may go to its bank right now
    function row_hit;
        input open;
        input [`LPC_ROW_W-1:0] held;
        input [`LPC_ROW_W-1:0] want;
        begin
            row_hit = open && (held == want);
        end
    endfunction

    // Four-deep queue decouples the user from power-up and row opens
    lpc_fifo #(
        .WIDTH(`LPC_WORD_W),
        .DEPTH(4),
        .AW(2)
    ) u_fifo (
        .clk(CLK),
        .srst(SRST),
        .in_valid(CMD_VALID),
        .in_ready(CMD_READY),
        .in_data({CMD_OP, CMD_BANK, CMD_ROW, CMD_COL}),
        .out_valid(q_valid),
        .out_ready(pop),
        .out_data(q_word)
    );

    assign q_op = q_word[`LPC_F_OP];
    assign q_bank = q_word[`LPC_F_BANK];
    assign q_row = q_word[`LPC_F_ROW];
    assign q_col = q_word[`LPC_F_COL];

    // Both bus halves built from one command each cycle
    lpc_ca_pack u_pack (
        .code(next_code),
        .bank(next_bank),
        .row(next_row),
        .col(next_col),
        .ca_rise(pk_rise),
        .ca_fall(pk_fall)
    );

    // Board pins are asynchronous to CLK
    always @(posedge CLK) begin
        if (SRST) begin
            ramp_meta <= 1'b0;
            ramp_sync <= 1'b0;
            dai_meta <= 1'b0;
            dai_sync <= 1'b0;
        end else begin
            ramp_meta <= RAMP_DONE;
            ramp_sync <= ramp_meta;
            dai_meta <= DAI_DONE;
            dai_sync <= dai_meta;
        end
    end

    // Sequencer decisions and the command chosen for the next cycle
    always @* begin
        next_state = state;
        next_code = `LPC_CODE_NOP;
        next_cke = CKE;
        next_bank = q_bank;
        next_row = q_row;
        next_col = q_col;
        pop = 1'b0;
        set_open = 1'b0;
        clr_open = 1'b0;
        clr_all = 1'b0;
        case (state)
            S_RAMP: begin
                next_cke = 1'b0;
                if (ramp_sync) begin
                    next_state = S_HOLD;
                end
            end
            S_HOLD: begin
                // Clock has run since reset; hold covers both minimums
                next_cke = 1'b0;
                if (cnt >= HOLD_CYC - 1'b1) begin
                    next_state = S_IDLE;
                    next_cke = 1'b1;
                end
            end
            S_IDLE: begin
                next_cke = 1'b1;
                if (cnt >= IDLE_CYC - 1'b1) begin
                    next_state = (USE_PREA != 0) ? S_PREA : S_RST;
                end
            end
            S_PREA: begin
                next_code = `LPC_CODE_PREA;
                clr_all = 1'b1;
                next_state = S_RST;
            end
            S_RST: begin
                next_code = `LPC_CODE_MRW;
                next_col = {3'h0, `LPC_MA_RESET};
                next_row = {`LPC_ROW_W{1'b0}};
                clr_all = 1'b1;
                next_state = S_DAI;
            end
            S_DAI: begin
                // Flag counts only once the post-reset idle has passed
                if ((cnt >= INIT5_CYC - 1'b1) ||
                        (dai_sync && cnt >= INIT4_CYC - 1'b1)) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                if (q_valid) begin
                    case (q_op)
                        `LPC_OP_READ, `LPC_OP_WRITE: begin
                            if (!bank_open[q_bank]) begin
                                next_code = `LPC_CODE_ACT;
                                set_open = 1'b1;
                            end else if (!row_hit(bank_open[q_bank],
                                    open_row[q_bank], q_row)) begin
                                next_code = `LPC_CODE_PRE;
                                clr_open = 1'b1;
                            end else begin
                                pop = 1'b1;
                                next_code = (q_op == `LPC_OP_READ)
                                    ? `LPC_CODE_READ
                                    : `LPC_CODE_WRITE;
                            end
                        end
                        `LPC_OP_PRE: begin
                            pop = 1'b1;
                            next_code = `LPC_CODE_PRE;
                            clr_open = 1'b1;
                        end
                        `LPC_OP_MRW: begin
                            pop = 1'b1;
                            next_code = `LPC_CODE_MRW;
                        end
                        `LPC_OP_MRR: begin
                            pop = 1'b1;
                            next_code = `LPC_CODE_MRR;
                        end
                        default: begin
                            pop = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                next_state = S_RAMP;
            end
        endcase
    end

    // State, interval counter and registered pins
    always @(posedge CLK) begin
        if (SRST) begin
            state <= S_RAMP;
            cnt <= {`LPC_CNT_W{1'b0}};
            CK_EN <= 1'b0;
            CKE <= 1'b0;
            CS_N <= 1'b1;
            CA_RISE <= {`LPC_CA_W{1'b0}};
            CA_FALL <= {`LPC_CA_W{1'b0}};
            INIT_DONE <= 1'b0;
            RELAXED <= 1'b1;
        end else begin
            state <= next_state;
            // Counter restarts on every state change
            if (next_state != state) begin
                cnt <= {`LPC_CNT_W{1'b0}};
            end else if (cnt != {`LPC_CNT_W{1'b1}}) begin
                cnt <= cnt + 1'b1;
            end
            CK_EN <= 1'b1;
            CKE <= next_cke;
            // Deselect doubles as no-operation
            CS_N <= (next_code == `LPC_CODE_NOP);
            CA_RISE <= pk_rise;
            CA_FALL <= pk_fall;
            INIT_DONE <= (next_state == S_RUN);
            // Read capture uses relaxed strobe timing until running
            RELAXED <= (next_state != S_RUN);
        end
    end

    // Open-row bookkeeping; reset and precharge-all close every bank
    always @(posedge CLK) begin
        if (SRST || clr_all) begin
            bank_open <= {BANKS{1'b0}};
        end else if (set_open) begin
            bank_open[q_bank] <= 1'b1;
        end else if (clr_open) begin
            bank_open[q_bank] <= 1'b0;
        end
    end

    // Row held per open bank; only read while its open bit is set
    always @(posedge CLK) begin
        if (set_open) begin
            open_row[q_bank] <= q_row;
        end
    end

    // MODE_REG_READ_CMD during polling is not used; BOOT_MRR_OK documents the limit
    wire unused_boot = BOOT_MRR_OK;
endmodule

// >>> testbench/lpc_ctrl_checker.sv
/*
 * Concurrent checks on the controller's memory pins during power-up and
 * while commands are issued.
 * Assumes the 250 MHz clock; bound into every instance of lpc_ctrl.
 */
`include "lpc_defines.vh"

module lpc_ctrl_checker #(
    parameter INIT3_CYC = 40
) (
    // Clock, reset and board status
    input wire CLK,
    input wire SRST,
    input wire RAMP_DONE,
    // Memory pins
    input wire CK_EN,
    input wire CKE,
    input wire CS_N,
    input wire [`LPC_CA_W-1:0] CA_RISE,
    // Status
    input wire INIT_DONE,
    input wire RELAXED
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    wire [3:0] code = CA_RISE[3:0];
    wire rst_cmd = !CS_N && code == 4'h6 && CA_RISE[9:4] == 6'h3f;
    reg [17:0] idle_cnt;
    reg [12:0] wait_cnt;

    // Cycles since enable rose and since the reset write; both saturate
    always @(posedge CLK) begin
        if (SRST || !CKE)
            idle_cnt <= 18'h0;
        else if (idle_cnt < INIT3_CYC)
            idle_cnt <= idle_cnt + 18'h1;
        if (SRST || rst_cmd)
            wait_cnt <= 13'h1;
        else if (wait_cnt != 13'h1fff)
            wait_cnt <= wait_cnt + 13'h1;
    end

    cke_ramp_low_a:
        assert property (!RAMP_DONE |-> !CKE)
        else $error("clock enable high before ramp done");
    cke_hold_a:
        assert property ($rose(CKE) |-> $past(RAMP_DONE, 25))
        else $error("clock enable rose too soon after ramp");
    clk_settle_a:
        assert property ($rose(CKE) |-> $past(CK_EN, 5))
        else $error("clock not running before enable");
    cke_kept_a:
        assert property (CKE |=> CKE)
        else $error("clock enable dropped");
    boot_nop_a:
        assert property (CKE && idle_cnt < INIT3_CYC |-> CS_N)
        else $error("command during idle period");
    boot_cmds_a:
        assert property (!CS_N && !INIT_DONE |-> code == 4'h5 || rst_cmd)
        else $error("wrong command during boot");
    prea_rst_a:
        assert property (!CS_N && code == 4'h5 && !INIT_DONE
                         |-> ##[1:4] rst_cmd)
        else $error("no reset write after precharge all");
    dai_wait_a:
        assert property ($rose(INIT_DONE)
                         |-> wait_cnt >= 13'd250 && wait_cnt <= 13'd2510)
        else $error("auto-init wait out of range");
    relaxed_a:
        assert property (RELAXED == !INIT_DONE)
        else $error("relaxed flag disagrees with run state");

    cover property ($rose(CKE));
    cover property (rst_cmd);
    cover property ($rose(INIT_DONE));
endmodule

bind lpc_ctrl lpc_ctrl_checker #(.INIT3_CYC(INIT3_CYC)) u_lpc_ctrl_checker (
    .CLK(CLK), .SRST(SRST), .RAMP_DONE(RAMP_DONE), .CK_EN(CK_EN),
    .CKE(CKE), .CS_N(CS_N), .CA_RISE(CA_RISE), .INIT_DONE(INIT_DONE),
    .RELAXED(RELAXED)
);

// >>> testbench/lpc_mem_model.sv
/*
 * Behavioural memory on the far side of the command bus: bank rows, a
 * log of accesses and the auto-init flag.
 * Assumes the controller's command layout; loses its open rows and
 * auto-init state while the clock enable is low; the log and counters are kept.
 */
`include "lpc_defines.vh"

module lpc_mem_model #(
    parameter DAI_CYC = 300
) (
    // Pins from the controller
    input wire clk,
    input wire cke,
    input wire cs_n,
    input wire [`LPC_CA_W-1:0] ca_rise,
    input wire [`LPC_CA_W-1:0] ca_fall,
    // Test control: never report auto-init done
    input wire dai_slow,
    // Auto-init done flag
    output logic dai_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic open_q [8];
    logic [12:0] row_q [8];
    logic [27:0] log_q [$];
    logic rst_seen;
    int acts;
    int viol;
    int dai_cnt;
    wire [3:0] code = ca_rise[3:0];
    wire [2:0] bank = ca_rise[6:4];

    // One command per cycle, both bus halves taken together
    always @(posedge clk) begin
        if (cke !== 1'b1) begin
            dai_done <= 1'b0;
            rst_seen <= 1'b0;
            foreach (open_q[i]) open_q[i] <= 1'b0;
        end else begin
            if (rst_seen && dai_cnt < DAI_CYC)
                dai_cnt <= dai_cnt + 1;
            dai_done <= rst_seen && dai_cnt >= DAI_CYC && !dai_slow;
            if (!cs_n) begin
                case (code)
                    4'h1: begin
                        if (open_q[bank] || !dai_done)
                            viol <= viol + 1;
                        open_q[bank] <= 1'b1;
                        row_q[bank] <= {ca_fall, ca_rise[9:7]};
                        acts <= acts + 1;
                    end
                    4'h2, 4'h3: begin
                        if (!open_q[bank] || !dai_done)
                            viol <= viol + 1;
                        // One log entry per burst, no beats
                        log_q.push_back({code[0], bank, row_q[bank],
                                         ca_fall[7:0], ca_rise[9:7]});
                    end
                    4'h4: open_q[bank] <= 1'b0;
                    4'h5: foreach (open_q[i]) open_q[i] <= 1'b0;
                    4'h6: begin
                        if ({ca_fall[1:0], ca_rise[9:4]} == `LPC_MA_RESET) begin
                            rst_seen <= 1'b1;
                            dai_cnt <= 0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// >>> testbench/tb_lpc_ctrl.sv
/*
 * Self-checking bench for the power-up and command controller, with the
 * behavioural memory on its pins.
 * Assumes a shortened idle time; everything else at its real count.
 */
`include "lpc_defines.vh"

module tb_lpc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int INIT3 = 40;
    logic clk, srst, ramp_done, cmd_valid, dai_slow;
    logic [2:0] cmd_op, cmd_bank;
    logic [12:0] cmd_row;
    logic [10:0] cmd_col;
    wire cmd_ready, ck_en, cke, cs_n, init_done, relaxed, dai_done;
    wire [9:0] ca_rise, ca_fall;
    int err_count, checked, cyc;

    lpc_ctrl #(.INIT3_CYC(INIT3)) u_lpc_ctrl (
        .CLK(clk), .SRST(srst), .RAMP_DONE(ramp_done), .DAI_DONE(dai_done),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
        .CMD_BANK(cmd_bank), .CMD_ROW(cmd_row), .CMD_COL(cmd_col),
        .CK_EN(ck_en), .CKE(cke), .CS_N(cs_n), .CA_RISE(ca_rise),
        .CA_FALL(ca_fall), .INIT_DONE(init_done), .RELAXED(relaxed));
    lpc_mem_model u_lpc_mem_model (
        .clk(clk), .cke(cke), .cs_n(cs_n), .ca_rise(ca_rise),
        .ca_fall(ca_fall), .dai_slow(dai_slow), .dai_done(dai_done));

    // Clock, plus a ceiling on the whole run in case something hangs
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Hold the word until an edge that finds the queue ready
    task automatic push(input logic [2:0] op, input logic [2:0] b,
                        input logic [12:0] r, input logic [10:0] c);
        logic rdy;
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_bank <= b;
        cmd_row <= r;
        cmd_col <= c;
        do begin
            @(negedge clk);
            rdy = cmd_ready;
            @(posedge clk);
        end while (rdy !== 1'b1);
    endtask

    // Queue four accesses while the ramp is still running
    task automatic t_fill();
        push(`LPC_OP_READ, 3'h2, 13'h0005, 11'h123);
        push(`LPC_OP_WRITE, 3'h2, 13'h0005, 11'h7ff);
        push(`LPC_OP_READ, 3'h2, 13'h0009, 11'h000);
        push(`LPC_OP_WRITE, 3'h7, 13'h1fff, 11'h001);
        cmd_valid <= 1'b0;
        repeat (20) begin
            @(negedge clk);
            chk({cke, cs_n, cmd_ready}, 3'b010);
        end
    endtask

    // Release the ramp and count cycles to enable and to run state
    task automatic t_boot(input int min_n, input int max_n);
        int n, m;
        n = 0;
        m = 0;
        // Ramp pin changes just after a rising edge
        @(posedge clk);
        ramp_done <= 1'b1;
        do begin
            @(negedge clk);
            n++;
            if (cke !== 1'b1)
                m = n;
        end while (init_done !== 1'b1 && n < 3000);
        chk(m >= 25, 1);
        chk(n - m >= INIT3 + 250, 1);
        chk(n >= min_n && n <= max_n, 1);
        chk({init_done, relaxed}, 2'b10);
        @(posedge clk);
    endtask

    // Queued accesses come out in order, rows opened as needed
    task automatic t_drain();
        logic [27:0] exp_q [4];
        exp_q = '{{1'b0, 3'h2, 13'h0005, 11'h123},
                  {1'b1, 3'h2, 13'h0005, 11'h7ff},
                  {1'b0, 3'h2, 13'h0009, 11'h000},
                  {1'b1, 3'h7, 13'h1fff, 11'h001}};
        for (int i = 0; i < 300 && u_lpc_mem_model.log_q.size() < 4; i++)
            @(negedge clk);
        foreach (exp_q[i])
            chk(u_lpc_mem_model.log_q[i], exp_q[i]);
        chk(u_lpc_mem_model.acts, 3);
        chk(u_lpc_mem_model.viol, 0);
        @(posedge clk);
    endtask

    // Mode register and precharge commands reach the pins in order
    task automatic t_misc();
        logic [19:0] exp_q [3];
        int k;
        exp_q = '{{8'h5a, 2'h0, 6'h02, 4'h6},
                  {10'h000, 3'h0, 3'h7, 4'h4},
                  {8'h00, 2'h0, 6'h05, 4'h7}};
        k = 0;
        fork
            begin
                push(`LPC_OP_MRW, 3'h0, 13'h005a, 11'h002);
                push(`LPC_OP_PRE, 3'h7, 13'h0000, 11'h000);
                push(`LPC_OP_MRR, 3'h0, 13'h0000, 11'h005);
                cmd_valid <= 1'b0;
            end
            for (int i = 0; i < 40 && k < 3; i++) begin
                @(negedge clk);
                if (cs_n === 1'b0) begin
                    chk({ca_fall, ca_rise}, exp_q[k]);
                    k++;
                end
            end
        join
        chk(k, 3);
        chk(u_lpc_mem_model.open_q[7], 0);
        @(posedge clk);
    endtask

    // Reset in mid-run; the device never reports auto-init done
    task automatic t_slow();
        srst <= 1'b1;
        ramp_done <= 1'b0;
        dai_slow <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk({ck_en, cke, cs_n, init_done, relaxed}, 5'b10101);
        t_boot(25 + INIT3 + 2500, 2800);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        ramp_done = 1'b0;
        dai_slow = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_bank = 3'h0;
        cmd_row = 13'h0;
        cmd_col = 11'h0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_fill();
        t_boot(25 + INIT3 + 250, 2500);
        t_drain();
        t_misc();
        t_slow();
        results();
    end
endmodule
